// *** core/mpe_map.svh ***
// register map, field positions, reset values and timing figures
`ifndef MPE_MAP_SVH
`define MPE_MAP_SVH

`define MPE_ADDR_W       6
`define MPE_REG_CTRL     6'h00
`define MPE_REG_NODES    6'h01
`define MPE_REG_BAUD     6'h02
`define MPE_REG_SLVTO    6'h03
`define MPE_REG_TCPPORT  6'h04
`define MPE_REG_TGTIP    6'h05
`define MPE_REG_UPDATE   6'h06
`define MPE_REG_RETRY    6'h07
`define MPE_REG_RSPTO    6'h08
`define MPE_REG_STATUS   6'h09
`define MPE_REG_INTCLR   6'h0a
`define MPE_REG_INTEN    6'h0b
`define MPE_REG_STATE    6'h0c
`define MPE_REG_AUX0     6'h10
`define MPE_AUX_N        4
`define MPE_AUX_IDX_W    2

// control bits
`define MPE_CTRL_EN      0
`define MPE_CTRL_MASTER  1
`define MPE_CTRL_TCP     2
`define MPE_CTRL_AUXEN   3
`define MPE_CTRL_SINGLE  4
`define MPE_CTRL_PAR_LO  5
`define MPE_CTRL_PAR_HI  6
`define MPE_CTRL_W       7

// parity encodings
`define MPE_PAR_NONE     2'h0
`define MPE_PAR_ODD      2'h1
`define MPE_PAR_EVEN     2'h2

// status / interrupt bits
`define MPE_ST_SLVTO     0
`define MPE_ST_FAIL      1
`define MPE_ST_DONE      2
`define MPE_ST_ACCEPT    3
`define MPE_ST_W         4

// aux entry fields
`define MPE_AUX_NODE_HI  7
`define MPE_AUX_NODE_LO  0
`define MPE_AUX_WRITE    8
`define MPE_AUX_CNT_HI   23
`define MPE_AUX_CNT_LO   16

// reset values
`define MPE_RST_BAUD     24'h004b00
`define MPE_RST_SLVTO    16'h03e8
`define MPE_RST_UPDATE   16'h0064
`define MPE_RST_RETRY    8'h03
`define MPE_RST_RSPTO    16'h01f4
`define MPE_TCP_DEFAULT  16'h01f6

// function codes
`define MPE_FC_READ      8'h03
`define MPE_FC_WR_SINGLE 8'h06
`define MPE_FC_WR_MULTI  8'h10

// timing
`define MPE_CLK_HZ       32'h0ee6b280
`define MPE_CLK_NS       4
`define MPE_MS_NS        1000000
`define MPE_MS_CYCLES    (`MPE_MS_NS / `MPE_CLK_NS)

`endif

// *** core/mpe_pkg.sv ***
// types shared by the port engine modules
package mpe_pkg;

   typedef enum logic [1:0] {
      MS_IDLE,
      MS_SEND,
      MS_WAIT
   } mpe_mstate_t;

   typedef struct packed {
      logic [6:0]        ctrl;
      logic [7:0]        localNode;
      logic [7:0]        targetNode;
      logic [23:0]       baud;
      logic [15:0]       slvTo;
      logic [15:0]       tcpPort;
      logic [31:0]       tgtIp;
      logic [15:0]       updMs;
      logic [7:0]        retryLim;
      logic [15:0]       rspToMs;
      logic [3:0]        status;
      logic [3:0]        intEn;
      logic [3:0][31:0]  aux;
      mpe_mstate_t       mst;
      logic [15:0]       updCnt;
      logic [15:0]       toCnt;
      logic [15:0]       slvCnt;
      logic [7:0]        retries;
      logic [1:0]        entry;
      logic [31:0]       rdData;
      logic              irq;
      logic              txValid;
      logic [7:0]        txNode;
      logic [7:0]        txFunc;
      logic [7:0]        txCount;
      logic [31:0]       txIp;
      logic [15:0]       txPort;
      logic              rxAccept;
      logic              charParity;
   } mpe_state_t;

   typedef struct packed {
      logic [31:0] msCnt;
      logic [31:0] baudAcc;
      logic        msTick;
      logic        baudTick;
   } mpe_tb_state_t;

endpackage

// *** core/mpe_tick_if.sv ***
// time base signals between engine and tick generator
`timescale 1ns/1ns
interface mpe_tick_if;
   logic [23:0] baudRate;
   logic        msTick;
   logic        baudTick;

   modport gen (input baudRate, output msTick, output baudTick);
   modport use_ (output baudRate, input msTick, input baudTick);
endinterface

// *** core/mpe_timebase.sv ***
// millisecond tick and bit-rate tick generator
`timescale 1ns/1ns
`include "mpe_map.svh"
module mpe_timebase
   import mpe_pkg::*;
#(
   parameter logic [31:0] MS_CYCLES = `MPE_MS_CYCLES
) (
   input  wire logic mclk,
   input  wire logic nrst,
   mpe_tick_if.gen   tb
);

   mpe_tb_state_t s;
   mpe_tb_state_t next_s;

   always_comb begin
      next_s          = s;
      next_s.msTick   = 1'b0;
      next_s.baudTick = 1'b0;
      if (s.msCnt >= MS_CYCLES - 32'h1) begin
         next_s.msCnt  = 32'h0;
         next_s.msTick = 1'b1;
      end else begin
         next_s.msCnt = s.msCnt + 32'h1;
      end
      // phase accumulator: one tick per bit at the configured rate (see RQ2)
      if (s.baudAcc + {8'h0, tb.baudRate} >= `MPE_CLK_HZ) begin
         next_s.baudAcc  = s.baudAcc + {8'h0, tb.baudRate} - `MPE_CLK_HZ;
         next_s.baudTick = 1'b1;
      end else begin
         next_s.baudAcc = s.baudAcc + {8'h0, tb.baudRate};
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tb.msTick   = s.msTick;
   assign tb.baudTick = s.baudTick;

endmodule

// *** core/mpe_engine.sv ***
// modbus port engine: configuration, slave answer, master poll scheduler
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "mpe_map.svh"

// Overview of operation
// (RQ1) slave answers only its local node
// (RQ2) serial bit tick at configured baud
// (RQ3) each character carries configured parity
// (RQ4) slave supervision timeout in milliseconds
// (RQ5) tcp port from config, zero means 502
// (RQ6) master polls the configured target node
// (RQ7) tcp master polls the configured target address
// (RQ8) polls spaced by update period in ms
// (RQ9) failed request retried up to limit
// (RQ10) reply awaited at most response timeout
// (RQ11) aux map polls several remote slaves
// (RQ12) aux map replaces automatic target polling
// (RQ13) single write code when count is one
// (RQ14) retries exhausted: abandon, flag, wait period
module mpe_engine
   import mpe_pkg::*;
#(
   parameter logic [31:0] MS_CYCLES = `MPE_MS_CYCLES
) (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire logic [`MPE_ADDR_W-1:0] addr,
   input  wire logic [31:0]           wrData,
   input  wire logic                  wrStrobe,
   input  wire logic                  rdStrobe,
   output logic      [31:0]           rdData,
   output logic                       irq,
   input  wire logic                  rxReqValid,
   input  wire logic [7:0]            rxNode,
   output logic                       rxAccept,
   output logic                       txValid,
   output logic      [7:0]            txNode,
   output logic      [7:0]            txFunc,
   output logic      [7:0]            txCount,
   output logic      [31:0]           txIp,
   output logic      [15:0]           txPort,
   input  wire logic                  rspValid,
   input  wire logic [7:0]            rspNode,
   input  wire logic                  rspOk,
   input  wire logic [7:0]            txChar,
   output logic                       charParity,
   output logic                       bitTick
);

   mpe_state_t s;
   mpe_state_t next_s;
   logic       bitTickQ;

   mpe_tick_if tb ();

   mpe_timebase #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timebase (
      .mclk (mclk),
      .nrst (nrst),
      .tb   (tb.gen)
   );

   // configured bit rate drives the tick generator
   assign tb.baudRate = s.baud;

   logic       enable;
   logic       isMaster;
   logic       isTcp;
   logic       auxEn;
   logic       singleWr;
   logic [1:0] parMode;
   logic [31:0] curAux;

   assign enable   = s.ctrl[`MPE_CTRL_EN];
   assign isMaster = s.ctrl[`MPE_CTRL_MASTER];
   assign isTcp    = s.ctrl[`MPE_CTRL_TCP];
   assign auxEn    = s.ctrl[`MPE_CTRL_AUXEN];
   assign singleWr = s.ctrl[`MPE_CTRL_SINGLE];
   assign parMode  = s.ctrl[`MPE_CTRL_PAR_HI:`MPE_CTRL_PAR_LO];
   assign curAux   = s.aux[s.entry];

   always_comb begin
      logic [3:0]  ev;
      logic [3:0]  clr;
      logic        pollDue;
      logic        advance;
      ev      = 4'h0;
      clr     = 4'h0;
      pollDue = 1'b0;
      advance = 1'b0;
      next_s  = s;
      next_s.txValid  = 1'b0;
      next_s.rxAccept = 1'b0;

      // register writes
      if (wrStrobe) begin
         case (addr)
            `MPE_REG_CTRL:    next_s.ctrl = wrData[`MPE_CTRL_W-1:0];
            `MPE_REG_NODES: begin
               next_s.localNode  = wrData[7:0];
               next_s.targetNode = wrData[15:8];
            end
            `MPE_REG_BAUD:    next_s.baud     = wrData[23:0];
            `MPE_REG_SLVTO:   next_s.slvTo    = wrData[15:0];
            `MPE_REG_TCPPORT: next_s.tcpPort  = wrData[15:0];
            `MPE_REG_TGTIP:   next_s.tgtIp    = wrData;
            `MPE_REG_UPDATE:  next_s.updMs    = wrData[15:0];
            `MPE_REG_RETRY:   next_s.retryLim = wrData[7:0];
            `MPE_REG_RSPTO:   next_s.rspToMs  = wrData[15:0];
            // write ones to clear status bits
            `MPE_REG_INTCLR:  clr             = wrData[`MPE_ST_W-1:0];
            `MPE_REG_INTEN:   next_s.intEn    = wrData[`MPE_ST_W-1:0];
            default: begin
               if (addr >= `MPE_REG_AUX0 &&
                   addr < `MPE_REG_AUX0 + `MPE_ADDR_W'(`MPE_AUX_N)) begin
                  next_s.aux[addr[`MPE_AUX_IDX_W-1:0]] = wrData;
               end
            end
         endcase
      end

      // register reads, data in the following cycle only
      next_s.rdData = 32'h0;
      if (rdStrobe) begin
         case (addr)
            `MPE_REG_CTRL:    next_s.rdData = {25'h0, s.ctrl};
            `MPE_REG_NODES:   next_s.rdData = {16'h0, s.targetNode, s.localNode};
            `MPE_REG_BAUD:    next_s.rdData = {8'h0, s.baud};
            `MPE_REG_SLVTO:   next_s.rdData = {16'h0, s.slvTo};
            `MPE_REG_TCPPORT: next_s.rdData = {16'h0, s.tcpPort};
            `MPE_REG_TGTIP:   next_s.rdData = s.tgtIp;
            `MPE_REG_UPDATE:  next_s.rdData = {16'h0, s.updMs};
            `MPE_REG_RETRY:   next_s.rdData = {24'h0, s.retryLim};
            `MPE_REG_RSPTO:   next_s.rdData = {16'h0, s.rspToMs};
            `MPE_REG_STATUS:  next_s.rdData = {28'h0, s.status};
            `MPE_REG_INTEN:   next_s.rdData = {28'h0, s.intEn};
            // fsm, entry index and retry count for software
            `MPE_REG_STATE:
               next_s.rdData = {12'h0, s.retries, 2'h0, s.entry, 6'h0, s.mst};
            default: begin
               if (addr >= `MPE_REG_AUX0 &&
                   addr < `MPE_REG_AUX0 + `MPE_ADDR_W'(`MPE_AUX_N)) begin
                  next_s.rdData = s.aux[addr[`MPE_AUX_IDX_W-1:0]];
               end
            end
         endcase
      end

      // character parity
      case (parMode)
         `MPE_PAR_ODD:  next_s.charParity = ~^txChar; // see RQ3
         `MPE_PAR_EVEN: next_s.charParity = ^txChar; // see RQ3
         default:       next_s.charParity = 1'b0;
      endcase

      // effective tcp port
      if (s.tcpPort == 16'h0) begin
         next_s.txPort = `MPE_TCP_DEFAULT; // see RQ5
      end else begin
         next_s.txPort = s.tcpPort; // see RQ5
      end

      // slave side: station address match and supervision
      // zero slave timeout turns supervision off
      if (enable && !isMaster) begin
         if (rxReqValid && rxNode == s.localNode) begin
            next_s.rxAccept = 1'b1; // see RQ1
            ev[`MPE_ST_ACCEPT] = 1'b1;
            next_s.slvCnt = 16'h0;
         end else if (tb.msTick && s.slvTo != 16'h0) begin
            if (s.slvCnt + 16'h1 >= s.slvTo) begin
               ev[`MPE_ST_SLVTO] = 1'b1; // see RQ4
               next_s.slvCnt = 16'h0;
            end else begin
               next_s.slvCnt = s.slvCnt + 16'h1;
            end
         end
      end else begin
         next_s.slvCnt = 16'h0;
      end

      // update period counter
      // a zero period behaves like one millisecond
      if (enable && isMaster) begin
         if (tb.msTick) begin
            if (s.updCnt + 16'h1 >= s.updMs) begin
               next_s.updCnt = 16'h0;
               pollDue = 1'b1; // see RQ8
            end else begin
               next_s.updCnt = s.updCnt + 16'h1;
            end
         end
      end else begin
         next_s.updCnt = 16'h0;
      end

      // master poll sequencer
      case (s.mst)
         MS_IDLE: begin
            next_s.retries = 8'h0;
            // a poll falling due while busy is dropped
            if (pollDue) begin
               next_s.mst = MS_SEND;
            end
         end
         MS_SEND: begin
            next_s.txValid = 1'b1;
            next_s.toCnt   = 16'h0;
            next_s.mst     = MS_WAIT;
            next_s.txIp    = isTcp ? s.tgtIp : 32'h0; // see RQ7
            if (auxEn) begin
               next_s.txNode  = curAux[`MPE_AUX_NODE_HI:`MPE_AUX_NODE_LO]; // see RQ11
               next_s.txCount = curAux[`MPE_AUX_CNT_HI:`MPE_AUX_CNT_LO];
               if (!curAux[`MPE_AUX_WRITE]) begin
                  next_s.txFunc = `MPE_FC_READ;
               end else if (singleWr &&
                            curAux[`MPE_AUX_CNT_HI:`MPE_AUX_CNT_LO] == 8'h1) begin
                  next_s.txFunc = `MPE_FC_WR_SINGLE; // see RQ13
               end else begin
                  next_s.txFunc = `MPE_FC_WR_MULTI;
               end
            end else begin
               // automatic polling only without the aux map (see RQ12)
               next_s.txNode  = s.targetNode; // see RQ6
               next_s.txCount = 8'h0;
               next_s.txFunc  = `MPE_FC_READ;
            end
         end
         MS_WAIT: begin
            // answers from other stations are ignored
            if (rspValid && rspNode == s.txNode && rspOk) begin
               ev[`MPE_ST_DONE] = 1'b1;
               advance    = 1'b1;
               next_s.mst = MS_IDLE;
            end else if ((rspValid && rspNode == s.txNode) ||
                         (tb.msTick && s.toCnt + 16'h1 >= s.rspToMs)) begin
               // failed or unanswered (see RQ10)
               // a limit of n allows n+1 transmissions
               if (s.retries < s.retryLim) begin
                  next_s.retries = s.retries + 8'h1; // see RQ9
                  next_s.mst     = MS_SEND;
               end else begin
                  ev[`MPE_ST_FAIL] = 1'b1; // see RQ14
                  advance    = 1'b1;
                  next_s.mst = MS_IDLE;
               end
            end else if (tb.msTick) begin
               next_s.toCnt = s.toCnt + 16'h1;
            end
         end
         default: next_s.mst = MS_IDLE;
      endcase

      // leaving master operation abandons a transfer
      if (!(enable && isMaster)) begin
         next_s.mst = MS_IDLE;
      end

      // step through aux entries after each finished transfer
      // four entries, the index wraps after the last
      if (advance && auxEn) begin
         next_s.entry = s.entry + 2'h1; // see RQ11
      end else if (!auxEn) begin
         next_s.entry = 2'h0;
      end

      // sticky status, set wins over clear
      next_s.status = (s.status & ~clr) | ev;
      next_s.irq    = |(next_s.status & next_s.intEn);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         // configuration returns to its default settings
         s          <= '0;
         s.baud     <= `MPE_RST_BAUD;
         s.slvTo    <= `MPE_RST_SLVTO;
         s.updMs    <= `MPE_RST_UPDATE;
         s.retryLim <= `MPE_RST_RETRY;
         s.rspToMs  <= `MPE_RST_RSPTO;
         s.txPort   <= `MPE_TCP_DEFAULT;
         s.mst      <= MS_IDLE;
         bitTickQ   <= 1'b0;
      end else begin
         s        <= next_s;
         bitTickQ <= tb.baudTick; // see RQ2
      end
   end

   // every output straight from a register
   assign rdData     = s.rdData;
   assign irq        = s.irq;
   assign rxAccept   = s.rxAccept;
   assign txValid    = s.txValid;
   assign txNode     = s.txNode;
   assign txFunc     = s.txFunc;
   assign txCount    = s.txCount;
   assign txIp       = s.txIp;
   assign txPort     = s.txPort;
   assign charParity = s.charParity;
   assign bitTick    = bitTickQ;

endmodule

// *** test/mpe_engine_monitor.sv ***
// assertion checker for the modbus port engine
`timescale 1ns/1ns
`include "mpe_map.svh"
module mpe_engine_monitor (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        rdStrobe,
   input wire logic [31:0] rdData,
   input wire logic        rxReqValid,
   input wire logic        rxAccept,
   input wire logic        txValid,
   input wire logic [7:0]  txNode,
   input wire logic [7:0]  txFunc,
   input wire logic [7:0]  txCount,
   input wire logic [15:0] txPort,
   input wire logic        bitTick
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_rd_idle; !rdStrobe |=> rdData == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_acc; rxAccept |-> $past(rxReqValid); endproperty
   a_acc: assert property (p_acc) else $error("accept without request");
   property p_tx_gap; txValid |=> !txValid [*2]; endproperty
   a_tx_gap: assert property (p_tx_gap) else $error("requests too close");
   property p_func;
      txValid |-> txFunc inside {`MPE_FC_READ, `MPE_FC_WR_SINGLE, `MPE_FC_WR_MULTI};
   endproperty
   a_func: assert property (p_func) else $error("bad function code");
   property p_single; txValid && txFunc == `MPE_FC_WR_SINGLE |-> txCount == 8'h01; endproperty
   a_single: assert property (p_single) else $error("single write count");
   property p_hold; !txValid |-> $stable(txNode) && $stable(txFunc) && $stable(txCount);
   endproperty
   a_hold: assert property (p_hold) else $error("request fields moved");
   property p_port; txPort != 16'h0; endproperty
   a_port: assert property (p_port) else $error("tcp port zero");
   property p_bit; bitTick |=> !bitTick; endproperty
   a_bit: assert property (p_bit) else $error("bit tick too long");
   c_accept: cover property (rxAccept);
   c_single: cover property (txValid && txFunc == `MPE_FC_WR_SINGLE);
   c_bit: cover property (bitTick);
endmodule
bind mpe_engine mpe_engine_monitor i_mon (
   .mclk       (mclk),
   .nrst       (nrst),
   .rdStrobe   (rdStrobe),
   .rdData     (rdData),
   .rxReqValid (rxReqValid),
   .rxAccept   (rxAccept),
   .txValid    (txValid),
   .txNode     (txNode),
   .txFunc     (txFunc),
   .txCount    (txCount),
   .txPort     (txPort),
   .bitTick    (bitTick)
);

// *** test/mpe_remote_slave.sv ***
// remote modbus slave answering the engine's polls
`timescale 1ns/1ns
module mpe_remote_slave (
   input  wire logic       mclk,
   input  wire logic       silent,
   input  wire logic [7:0] lat,
   input  wire logic       txValid,
   input  wire logic [7:0] txNode,
   output logic            rspValid,
   output logic [7:0]      rspNode,
   output logic            rspOk
);
   logic [7:0] cnt = 8'h0;
   logic [7:0] node = 8'h0;
   initial begin
      rspValid = 1'b0;
      rspNode = 8'hff;
      rspOk = 1'b0;
   end
   // idle lines show junk, never the last answer
   always @(posedge mclk) begin
      rspValid <= 1'b0;
      rspNode <= ~node;
      rspOk <= ~rspOk;
      if (txValid && !silent) begin
         cnt <= lat;
         node <= txNode;
      end else if (cnt == 8'h1) begin
         rspValid <= 1'b1;
         rspNode <= node;
         rspOk <= 1'b1;
         cnt <= 8'h0;
      end else if (cnt != 8'h0)
         cnt <= cnt - 8'h1;
   end
endmodule

// *** test/test_mpe_engine.sv ***
// self-checking bench for the modbus port engine
`timescale 1ns/1ns
`include "mpe_map.svh"
`define CHK(nm, e, v) begin total_checks++; if ((v) !== (e)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", nm, e, v); end end
module test_mpe_engine;
   localparam int MSC = 20;
   localparam logic [5:0] RA [9] = '{`MPE_REG_CTRL, `MPE_REG_BAUD, `MPE_REG_SLVTO,
      `MPE_REG_TCPPORT, `MPE_REG_UPDATE, `MPE_REG_RETRY, `MPE_REG_RSPTO, `MPE_REG_INTCLR, 6'h3f};
   localparam logic [31:0] RV [9] = '{32'h0, 32'(`MPE_RST_BAUD), 32'(`MPE_RST_SLVTO), 32'h0,
      32'(`MPE_RST_UPDATE), 32'(`MPE_RST_RETRY), 32'(`MPE_RST_RSPTO), 32'h0, 32'h0};
   localparam logic [31:0] AX [4] = '{32'h00040020, 32'h00010121, 32'h00020122, 32'h00010123};
   localparam logic [7:0] EF [4] = '{`MPE_FC_READ, `MPE_FC_WR_SINGLE, `MPE_FC_WR_MULTI,
      `MPE_FC_WR_SINGLE};
   localparam logic [7:0] EC [4] = '{8'h04, 8'h01, 8'h02, 8'h01};
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic [5:0]  addr = 6'h0;
   logic [31:0] wrData = 32'h0;
   logic        wrStrobe = 1'b0;
   logic        rdStrobe = 1'b0;
   logic        rxReqValid = 1'b0;
   logic [7:0]  rxNode = 8'h0;
   logic [7:0]  txChar = 8'h0;
   logic        silent = 1'b0;
   logic [7:0]  lat = 8'h03;
   logic [31:0] rdData, txIp;
   logic        irq, rxAccept, txValid, rspValid, rspOk, charParity, bitTick;
   logic [7:0]  txNode, txFunc, txCount, rspNode;
   logic [15:0] txPort;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          g, n;
   mpe_engine #(.MS_CYCLES(32'h14)) i_dut (.mclk(mclk), .nrst(nrst), .addr(addr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .irq(irq),
      .rxReqValid(rxReqValid), .rxNode(rxNode), .rxAccept(rxAccept), .txValid(txValid),
      .txNode(txNode), .txFunc(txFunc), .txCount(txCount), .txIp(txIp), .txPort(txPort),
      .rspValid(rspValid), .rspNode(rspNode), .rspOk(rspOk), .txChar(txChar),
      .charParity(charParity), .bitTick(bitTick));
   mpe_remote_slave i_far (.mclk(mclk), .silent(silent), .lat(lat), .txValid(txValid),
      .txNode(txNode), .rspValid(rspValid), .rspNode(rspNode), .rspOk(rspOk));
   initial begin
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge mclk);
      wrStrobe <= 1'b0;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge mclk);
      rdStrobe <= 1'b0;
      @(negedge mclk);
      `CHK("read data", e, rdData)
   endtask
   task automatic rx(input logic [7:0] nd, input logic e);
      @(posedge mclk);
      rxNode <= nd;
      rxReqValid <= 1'b1;
      @(posedge mclk);
      rxReqValid <= 1'b0;
      @(negedge mclk);
      `CHK("accept", e, rxAccept)
   endtask
   task automatic waitTx(output int gap);
      gap = 0;
      do begin
         @(negedge mclk);
         gap++;
      end while (txValid !== 1'b1 && gap < 1000);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 0; i < 9; i++) rdc(RA[i], RV[i]);
      wr(6'h3f, 32'hffffffff);
      wr(`MPE_REG_STATUS, 32'hf);
      rdc(6'h3f, 32'h0);
      rdc(`MPE_REG_STATUS, 32'h0);
      `CHK("port", `MPE_TCP_DEFAULT, txPort)
      wr(`MPE_REG_TCPPORT, 32'h1234);
      repeat (2) @(negedge mclk);
      `CHK("port", 16'h1234, txPort)
      wr(`MPE_REG_TCPPORT, 32'h0);
      repeat (2) @(negedge mclk);
      `CHK("port", `MPE_TCP_DEFAULT, txPort)
      for (int p = 0; p < 3; p++) begin
         wr(`MPE_REG_CTRL, 32'(p << 5) | 32'h1);
         for (int c = 3; c < 8; c += 4) begin
            @(posedge mclk) txChar <= 8'(c);
            repeat (2) @(negedge mclk);
            `CHK("parity", p == 0 ? 1'b0 : (p == 1) ^ (^8'(c)), charParity)
         end
      end
      wr(`MPE_REG_BAUD, 32'h00bebc20);
      n = 0;
      repeat (1000) @(negedge mclk) n += int'(bitTick);
      `CHK("bit ticks", 1'b1, n >= 49 && n <= 51)
      // slave side: address match, interrupt mask, supervision timeout
      wr(`MPE_REG_NODES, 32'h5a11);
      wr(`MPE_REG_SLVTO, 32'h3);
      rx(8'h22, 1'b0);
      rx(8'h11, 1'b1);
      `CHK("irq masked", 1'b0, irq)
      wr(`MPE_REG_INTEN, 32'ha);
      repeat (2) @(negedge mclk);
      `CHK("irq", 1'b1, irq)
      wr(`MPE_REG_INTCLR, 32'hf);
      repeat (2) @(negedge mclk);
      `CHK("irq cleared", 1'b0, irq)
      rdc(`MPE_REG_STATUS, 32'h0);
      repeat (60) @(negedge mclk);
      rdc(`MPE_REG_STATUS, 32'h1);
      wr(`MPE_REG_SLVTO, 32'h0);
      wr(`MPE_REG_INTCLR, 32'hf);
      // master: plain poll of the target
      wr(`MPE_REG_UPDATE, 32'h2);
      wr(`MPE_REG_RSPTO, 32'h3);
      wr(`MPE_REG_RETRY, 32'h2);
      wr(`MPE_REG_CTRL, 32'h3);
      rx(8'h11, 1'b0);
      waitTx(g);
      waitTx(g);
      `CHK("period", 2 * MSC, g)
      `CHK("node", 8'h5a, txNode)
      `CHK("func", `MPE_FC_READ, txFunc)
      `CHK("count", 8'h0, txCount)
      `CHK("ip", 32'h0, txIp)
      rdc(`MPE_REG_STATUS, 32'h4);
      @(posedge mclk) lat <= 8'h1e;
      wr(`MPE_REG_TGTIP, 32'hc0a80101);
      wr(`MPE_REG_CTRL, 32'h7);
      waitTx(g);
      waitTx(g);
      `CHK("ip", 32'hc0a80101, txIp)
      `CHK("node", 8'h5a, txNode)
      // auxiliary map with single writes, then without them (multiple write)
      for (int i = 0; i < 4; i++) wr(`MPE_REG_AUX0 + 6'(i), AX[i]);
      wr(`MPE_REG_CTRL, 32'h1b);
      waitTx(g);
      waitTx(g);
      n = int'(txNode[1:0]);
      for (int i = 0; i < 4; i++) begin
         if (i > 0)
            waitTx(g);
         `CHK("aux node", 8'h20 + 8'((n + i) % 4), txNode)
         `CHK("aux func", EF[(n + i) % 4], txFunc)
         `CHK("aux count", EC[(n + i) % 4], txCount)
      end
      wr(`MPE_REG_CTRL, 32'hb);
      n = 0;
      do begin
         waitTx(g);
         n++;
      end while (txNode !== 8'h21 && n < 6);
      `CHK("multi func", `MPE_FC_WR_MULTI, txFunc)
      // silent target: retries, timeout, abandon
      wr(`MPE_REG_CTRL, 32'h3);
      wr(`MPE_REG_UPDATE, 32'h14);
      @(posedge mclk) silent <= 1'b1;
      n = 0;
      do begin
         waitTx(g);
         n++;
      end while (g <= 100 && n < 8);
      wr(`MPE_REG_INTCLR, 32'hf);
      for (int i = 0; i < 2; i++) begin
         waitTx(g);
         `CHK("retry gap", 1'b1, g >= 2 * MSC && g <= 3 * MSC + 4)
      end
      waitTx(g);
      `CHK("no extra retry", 1'b1, g > 100)
      rdc(`MPE_REG_STATUS, 32'h2);
      `CHK("irq fail", 1'b1, irq)
      report_and_stop();
   end
endmodule
